// ---- hw/pmic_cfg_map.vh ----
`ifndef PMIC_CFG_MAP_VH
`define PMIC_CFG_MAP_VH

// register offsets
`define OFS_PASSWORD 8'h10
`define OFS_LIMIT_CFG 8'h14
`define OFS_PFAIL_CFG 8'h15
`define OFS_BUCK_ONE 8'h16

// reset values
`define RST_LIMIT_CFG 8'hC0
`define RST_PFAIL_CFG 8'h00
`define RST_BUCK_ONE 8'h99
`define RST_VCODE 6'h19
`define RST_PULSE_SKIP 1'b1
`define RST_UVLO_HYST 1'b1
`define RST_RDATA 8'h00
`define RST_SYNC 3'h7
`define RST_LEVEL 1'b1

// writable bits; everything else reads zero
`define MASK_LIMIT_CFG 8'hCF
`define MASK_PFAIL_CFG 8'h3F
`define MASK_BUCK_ONE 8'hBF

// field positions
`define BIT_WARM_ROUTE 7
`define BIT_UVLO_HYST 6
`define SW3_LIM_HI 3
`define SW3_LIM_LO 2
`define SW2_LIM_HI 1
`define SW2_LIM_LO 0
`define PFOFF_HI 5
`define PFOFF_LO 3
`define DISCH_HI 2
`define DISCH_LO 0
`define BIT_PULSE_SKIP 7
`define VCODE_HI 5
`define VCODE_LO 0

// unlock key, arbitrary value
`define PW_KEY_DEFAULT 8'h5A

// monitor blanking time and clock rate
`define MON_BLANK_MS 5
`define CLK_KHZ 125000

`endif

// ---- hw/pmic_cfg_regs.v ----
`timescale 1ns/10ps
`default_nettype none
`include "pmic_cfg_map.vh"

module pmic_cfg_regs #(
  parameter [7:0] PW_KEY = `PW_KEY_DEFAULT,
  parameter CNT_W = 20,
  parameter [CNT_W-1:0] BLANK_CYCLES = `MON_BLANK_MS * `CLK_KHZ
) (
  input wire mclk,
  input wire srst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg reg_wr_refused_q,
  input wire voltage_commit,
  input wire voltage_commit_with_disable,
  input wire [2:0] switch_enable,
  input wire powerfail_comparator_out,
  input wire general_pin_three_in,
  input wire general_pin_three_level,
  output reg general_pin_three_out_q,
  output reg general_pin_three_oe_q,
  output reg buck_pair_warm_reset_q,
  output reg uvlo_hyst_wide_q,
  output reg [1:0] switch_three_current_limit_q,
  output reg [1:0] switch_two_current_limit_q,
  output reg [2:0] switch_on_q,
  output reg [2:0] switch_discharge_q,
  output reg pulse_skip_enable_q,
  output reg [5:0] buck_one_vout_code_q,
  output reg monitor_blank_q
);

  reg [7:0] limit_cfg_q;
  reg [7:0] pfail_cfg_q;
  reg [7:0] buck_one_q;
  reg [7:0] unlock_addr_q;
  reg unlock_q;
  reg [CNT_W-1:0] blank_cnt_q;
  reg [2:0] pf_sync_q;
  reg pf_level_q;
  reg [2:0] pin_sync_q;
  reg pin_level_q;
  reg [7:0] limit_cfg_d;
  reg [7:0] pfail_cfg_d;
  reg [7:0] buck_one_d;
  reg [7:0] reg_rdata_d;
  reg [CNT_W-1:0] blank_cnt_d;
  reg monitor_blank_d;
  reg [5:0] buck_one_vout_code_d;
  reg [2:0] switch_on_d;
  reg [2:0] switch_discharge_d;
  reg general_pin_three_oe_d;
  reg buck_pair_warm_reset_d;

  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  wire hit_limit = reg_addr == `OFS_LIMIT_CFG;
  wire hit_pfail = reg_addr == `OFS_PFAIL_CFG;
  wire hit_buck = reg_addr == `OFS_BUCK_ONE;
  wire hit_pw = reg_addr == `OFS_PASSWORD;
  wire hit_prot = hit_limit | hit_pfail | hit_buck;
  wire wr_ok = reg_wr & hit_prot & unlock_q & (unlock_addr_q == reg_addr);
  // the disable half of a commit lives outside; here both commit alike
  wire commit = voltage_commit | voltage_commit_with_disable;

  // masked write keeps reserved bits at zero
  function [7:0] mwrite;
    input [7:0] data;
    input [7:0] mask;
    begin
      mwrite = data & mask;
    end
  endfunction

  // an input from a pin: level moves only when stages two and three agree
  function filt;
    input [2:0] s;
    input cur;
    begin
      filt = (s[1] == s[2]) ? s[2] : cur;
    end
  endfunction

  // power-fail pin idles high, so reset leaves no false trip behind
  always @(posedge mclk) begin
    if (srst) begin
      pf_sync_q <= `RST_SYNC;
      pf_level_q <= `RST_LEVEL;
    end else begin
      pf_sync_q <= {pf_sync_q[1:0], powerfail_comparator_out};
      pf_level_q <= filt(pf_sync_q, pf_level_q);
    end
  end

  // warm-reset request pin, active low, idles high
  always @(posedge mclk) begin
    if (srst) begin
      pin_sync_q <= `RST_SYNC;
      pin_level_q <= `RST_LEVEL;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], general_pin_three_in};
      pin_level_q <= filt(pin_sync_q, pin_level_q);
    end
  end

  // unlock: key xor target address, good for the very next write only
  always @(posedge mclk) begin
    if (srst) begin
      unlock_q <= 1'b0;
      unlock_addr_q <= 8'h00;
    end else if (reg_wr) begin
      // any write spends the unlock; a wrong key leaves it useless
      unlock_q <= hit_pw;
      unlock_addr_q <= reg_wdata ^ PW_KEY;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      reg_wr_refused_q <= 1'b0;
    end else begin
      reg_wr_refused_q <= reg_wr & hit_prot & ~wr_ok;
    end
  end

  always @* begin
    limit_cfg_d = limit_cfg_q;
    pfail_cfg_d = pfail_cfg_q;
    buck_one_d = buck_one_q;
    if (wr_ok & hit_limit) begin
      limit_cfg_d = mwrite(reg_wdata, `MASK_LIMIT_CFG);
    end
    if (wr_ok & hit_pfail) begin
      pfail_cfg_d = mwrite(reg_wdata, `MASK_PFAIL_CFG);
    end
    if (wr_ok & hit_buck) begin
      buck_one_d = mwrite(reg_wdata, `MASK_BUCK_ONE);
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      limit_cfg_q <= `RST_LIMIT_CFG;
      pfail_cfg_q <= `RST_PFAIL_CFG;
      buck_one_q <= `RST_BUCK_ONE;
    end else begin
      limit_cfg_q <= limit_cfg_d;
      pfail_cfg_q <= pfail_cfg_d;
      buck_one_q <= buck_one_d;
    end
  end

  // reads answer one cycle later; unmapped and password read zero
  function [7:0] read_mux;
    input [7:0] addr;
    input [7:0] lim;
    input [7:0] pfl;
    input [7:0] bck;
    begin
      case (addr)
        `OFS_LIMIT_CFG: read_mux = lim;
        `OFS_PFAIL_CFG: read_mux = pfl;
        `OFS_BUCK_ONE: read_mux = bck;
        default: read_mux = `RST_RDATA;
      endcase
    end
  endfunction

  // read data holds until the next read
  always @* begin
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      reg_rdata_d = read_mux(reg_addr, limit_cfg_q, pfail_cfg_q, buck_one_q);
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata_q <= `RST_RDATA;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // a rewrite during blanking restarts the full window
  // blank window start
  always @* begin
    blank_cnt_d = blank_cnt_q;
    monitor_blank_d = 1'b0;
    if (wr_ok & hit_buck) begin
      blank_cnt_d = BLANK_CYCLES;
      monitor_blank_d = 1'b1;
    end else if (blank_cnt_q != CNT_ZERO) begin
      blank_cnt_d = blank_cnt_q - CNT_ONE;
      monitor_blank_d = blank_cnt_q != CNT_ONE;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      blank_cnt_q <= CNT_ZERO;
      monitor_blank_q <= 1'b0;
    end else begin
      blank_cnt_q <= blank_cnt_d;
      monitor_blank_q <= monitor_blank_d;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      pulse_skip_enable_q <= `RST_PULSE_SKIP;
    end else begin
      pulse_skip_enable_q <= buck_one_q[`BIT_PULSE_SKIP];
    end
  end

  always @* begin
    buck_one_vout_code_d = buck_one_vout_code_q;
    if (commit) begin
      buck_one_vout_code_d = buck_one_q[`VCODE_HI:`VCODE_LO];
    end
  end

  // codes above the documented range pass unchanged
  always @(posedge mclk) begin
    if (srst) begin
      buck_one_vout_code_q <= `RST_VCODE;
    end else begin
      buck_one_vout_code_q <= buck_one_vout_code_d;
    end
  end

  always @* begin
    general_pin_three_oe_d = ~limit_cfg_q[`BIT_WARM_ROUTE] & ~general_pin_three_level;
    buck_pair_warm_reset_d = limit_cfg_q[`BIT_WARM_ROUTE] & ~pin_level_q;
  end

  // output is open drain: only ever pulled low, oe one pulls the pin down
  always @(posedge mclk) begin
    if (srst) begin
      general_pin_three_out_q <= 1'b0;
      general_pin_three_oe_q <= 1'b0;
      buck_pair_warm_reset_q <= 1'b0;
    end else begin
      general_pin_three_out_q <= 1'b0;
      general_pin_three_oe_q <= general_pin_three_oe_d;
      buck_pair_warm_reset_q <= buck_pair_warm_reset_d;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      uvlo_hyst_wide_q <= `RST_UVLO_HYST;
      switch_three_current_limit_q <= 2'h0;
      switch_two_current_limit_q <= 2'h0;
    end else begin
      uvlo_hyst_wide_q <= limit_cfg_q[`BIT_UVLO_HYST];
      switch_three_current_limit_q <= limit_cfg_q[`SW3_LIM_HI:`SW3_LIM_LO];
      switch_two_current_limit_q <= limit_cfg_q[`SW2_LIM_HI:`SW2_LIM_LO];
    end
  end

  always @* begin
    switch_on_d = switch_enable & ~(pfail_cfg_q[`PFOFF_HI:`PFOFF_LO] & {3{~pf_level_q}});
    switch_discharge_d = pfail_cfg_q[`DISCH_HI:`DISCH_LO] & ~switch_on_q;
  end

  // discharge trails the switch by a cycle, so the two overlap for one cycle when a switch turns on
  always @(posedge mclk) begin
    if (srst) begin
      switch_on_q <= 3'h0;
      switch_discharge_q <= 3'h0;
    end else begin
      switch_on_q <= switch_on_d;
      switch_discharge_q <= switch_discharge_d;
    end
  end

endmodule // pmic_cfg_regs
`default_nettype wire

// ---- testbench/pmic_cfg_chk_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmic_cfg_chk (
  input wire mclk,
  input wire srst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire reg_wr_refused_q,
  input wire voltage_commit,
  input wire voltage_commit_with_disable,
  input wire [2:0] switch_enable,
  input wire general_pin_three_oe_q,
  input wire buck_pair_warm_reset_q,
  input wire [2:0] switch_on_q,
  input wire [2:0] switch_discharge_q,
  input wire [5:0] buck_one_vout_code_q,
  input wire monitor_blank_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // last write: was it the unlock offset, and with which data
  reg [8:0] last_q;
  always @(posedge mclk) begin
    if (srst) last_q <= 9'h000;
    else if (reg_wr) last_q <= {reg_addr == 8'h10, reg_wdata};
  end
  wire buck_wr = reg_wr && reg_addr == 8'h16;
  property p_refuse;
    buck_wr && !last_q[8] |=> reg_wr_refused_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write not refused");
  property p_blank;
    buck_wr && last_q == 9'h14C |=> monitor_blank_q [*8];
  endproperty
  a_blank: assert property (p_blank) else $error("blank window short");
  property p_hold;
    !voltage_commit && !voltage_commit_with_disable |=> $stable(buck_one_vout_code_q);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved uncommitted");
  property p_sw;
    (switch_on_q & ~$past(switch_enable)) == 3'h0;
  endproperty
  a_sw: assert property (p_sw) else $error("switch on while disabled");
  property p_dis;
    (switch_discharge_q & $past(switch_on_q)) == 3'h0;
  endproperty
  a_dis: assert property (p_dis) else $error("discharge while on");
  property p_excl;
    !(general_pin_three_oe_q && buck_pair_warm_reset_q);
  endproperty
  a_excl: assert property (p_excl) else $error("pin both roles");
  property p_unmap;
    reg_rd && reg_addr == 8'h10 |=> reg_rdata_q == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_rsv;
    reg_rd && reg_addr == 8'h16 |=> !reg_rdata_q[6];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
endmodule // pmic_cfg_chk
bind pmic_cfg_regs pmic_cfg_chk u_chk (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  reg mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, vc = 0, vcd = 0, pf = 1, pin_in = 1, lvl = 1;
  reg [7:0] addr = 8'h00, wdata = 8'h00;
  reg [2:0] sw_en = 3'h0;
  wire [7:0] rdata;
  wire [5:0] vcode;
  wire [2:0] son, sdis;
  wire [1:0] lim3, lim2;
  wire refused, poe, warm, pskip, blank, pout, uvlo;
  integer n_fail = 0, tests_run = 0, i, k;
  reg [23:0] rows [0:7];
  pmic_cfg_regs #(.BLANK_CYCLES(20'd20)) dut (.mclk(mclk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata),
    .reg_wr_refused_q(refused), .voltage_commit(vc), .voltage_commit_with_disable(vcd),
    .switch_enable(sw_en), .powerfail_comparator_out(pf), .general_pin_three_in(pin_in),
    .general_pin_three_level(lvl), .general_pin_three_out_q(pout), .general_pin_three_oe_q(poe),
    .buck_pair_warm_reset_q(warm), .uvlo_hyst_wide_q(uvlo), .switch_three_current_limit_q(lim3),
    .switch_two_current_limit_q(lim2), .switch_on_q(son), .switch_discharge_q(sdis),
    .pulse_skip_enable_q(pskip), .buck_one_vout_code_q(vcode), .monitor_blank_q(blank));
  task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task op(input r, input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_rd <= r;
      reg_wr <= !r;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  // unlock with the target-specific key, then write
  task pw(input [7:0] a, input [7:0] d);
    begin
      op(1'b0, 8'h10, a ^ 8'h5A);
      op(1'b0, a, d);
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task results;
    begin
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial forever #4 mclk = ~mclk;
  initial begin
    rows[0] = 24'h14FFCF;
    rows[1] = 24'h143606;
    rows[2] = 24'h140909;
    rows[3] = 24'h140000;
    rows[4] = 24'h15FF3F;
    rows[5] = 24'h15C000;
    rows[6] = 24'h16FFBF;
    rows[7] = 24'h162323;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    op(1'b1, 8'h14, 8'h00);
    chk("rst14", 8'hC0, rdata);
    chk("uvlo", 8'h01, {7'h00, uvlo});
    chk("pskip", 8'h01, {7'h00, pskip});
    chk("blank", 8'h00, {7'h00, blank});
    chk("refuse", 8'h00, {7'h00, refused});
    op(1'b1, 8'h15, 8'h00);
    chk("rst15", 8'h00, rdata);
    op(1'b1, 8'h16, 8'h00);
    chk("rst16", 8'h99, rdata);
    chk("vrst", 8'h19, {2'h0, vcode});
    for (i = 0; i < 8; i = i + 1) begin
      pw(rows[i][23:16], rows[i][15:8]);
      op(1'b1, rows[i][23:16], 8'h00);
      chk("rdback", rows[i][7:0], rdata);
      if (rows[i][23:16] == 8'h14) chk("limit", rows[i][7:0] & 8'h0F, {4'h0, lim3, lim2});
      if (rows[i][23:16] == 8'h14) chk("uvlo", {7'h00, rows[i][6]}, {7'h00, uvlo});
      if (rows[i][23:16] == 8'h16) chk("pskip", {7'h00, rows[i][7]}, {7'h00, pskip});
    end
    for (k = 0; k < 2; k = k + 1) begin
      pw(8'h16, k ? 8'h00 : 8'h23);
      chk("held", k ? 8'h23 : 8'h19, {2'h0, vcode});
      @(posedge mclk);
      vc <= (k == 0);
      vcd <= (k == 1);
      @(posedge mclk);
      vc <= 1'b0;
      vcd <= 1'b0;
      #1;
      chk("vcode", k ? 8'h00 : 8'h23, {2'h0, vcode});
    end
    pw(8'h16, 8'h99);
    for (i = 0; blank === 1'b1 && i < 40; i = i + 1) wt(1);
    chk("blank", 8'd20, i[7:0]);
    // unlock is spent by the write to the other register
    pw(8'h15, 8'h3F);
    op(1'b0, 8'h16, 8'h00);
    chk("refuse", 8'h01, {7'h00, refused});
    op(1'b1, 8'h16, 8'h00);
    chk("kept", 8'h99, rdata);
    @(posedge mclk);
    sw_en <= 3'h7;
    wt(8);
    chk("on", 8'h07, {5'h00, son});
    chk("dis", 8'h00, {5'h00, sdis});
    @(posedge mclk);
    pf <= 1'b0;
    wt(8);
    chk("pfoff", 8'h00, {5'h00, son});
    chk("dis", 8'h07, {5'h00, sdis});
    pw(8'h15, 8'h00);
    wt(3);
    chk("ignpf", 8'h07, {5'h00, son});
    @(posedge mclk);
    lvl <= 1'b0;
    pin_in <= 1'b0;
    wt(8);
    chk("oe", 8'h01, {7'h00, poe});
    chk("warm", 8'h00, {7'h00, warm});
    chk("pout", 8'h00, {7'h00, pout});
    pw(8'h14, 8'h80);
    wt(3);
    chk("warm", 8'h01, {7'h00, warm});
    chk("oe", 8'h00, {7'h00, poe});
    op(1'b1, 8'h10, 8'h00);
    chk("unmap", 8'h00, rdata);
    // reset again in mid-run: registers and outputs go back to defaults
    @(posedge mclk);
    srst <= 1'b1;
    wt(2);
    chk("rsvc", 8'h19, {2'h0, vcode});
    chk("rsblk", 8'h00, {7'h00, blank});
    @(posedge mclk);
    srst <= 1'b0;
    op(1'b1, 8'h16, 8'h00);
    chk("rs16", 8'h99, rdata);
    op(1'b1, 8'h14, 8'h00);
    chk("rs14", 8'hC0, rdata);
    wt(3);
    chk("rswarm", 8'h01, {7'h00, warm});
    results;
  end
endmodule // testbench
`default_nettype wire
